// [pfa_port_a_pfc.sv]
// Port A direction and function selection, with debug fixing of port E pins
//
// Notes on behaviour
// - Direction bit 1 output, 0 input
// - Low direction bit n governs port A pin n, high direction bit n pin n+16
// - Low direction only for port or serial clocks
// - High direction only while pins 23..16 port
// - Direction registers reset to zero
// - High direction bits 15..8 read zero
// - Reduced variant disables high direction bits 7..0
// - Function registers 16 bits, read-write, pick functions
// - L1 bit 14: pin 15 clock output
// - L1 bit 12: pin 14 read strobe
// - L1 bit 10: pin 13 upper write strobe
// - Reduced variant reserved function bits read zero
// - Debug mode fixes port E pins to JTAG
// - Function bits reset to zero, port function
//
// Implementation choices: the address map and the AXI4-Lite register port.
`include "pfa_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module pfa_port_a_pfc #(
    parameter bit REDUCED_PIN = 1'b0          // Reduced-pin device variant
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [31:0] s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    input  wire logic [23:0] port_a_data,            // Port data register levels
    input  wire logic [23:0] port_a_pin_in,          // Pad input levels
    input  wire logic        clock_generator_out,    // Clock output source
    input  wire logic        read_strobe_out,        // Bus controller read strobe
    input  wire logic        upper_write_strobe_out, // Bus controller upper strobe
    input  wire logic [1:0]  serial_clock_sel,       // Serial clock one, zero in use
    input  wire logic        serial_clock_zero_out,  // Serial clock zero level
    input  wire logic        serial_clock_one_out,   // Serial clock one level
    output logic [23:0]      port_a_pad_out,         // Pad output levels
    output logic [23:0]      port_a_pad_oe_n,        // Pad drive enables, low drives
    input  wire logic        debug_mode_input,       // Emulator debug mode
    input  wire logic [4:0]  port_e_out,             // Port E pins 12..8 levels
    input  wire logic [4:0]  port_e_oe_n_in,         // Port E pins 12..8 enables
    input  wire logic        jtag_tdo,               // Test data out level
    output logic [4:0]       port_e_pad_out,         // Port E pads 12..8 levels
    output logic [4:0]       port_e_pad_oe_n,        // Port E pads 12..8 enables
    output logic             debug_pins_fixed        // Port E pins held for JTAG
);
    // Register file
    logic [15:0] dir_low_q;      // port_a_direction_low
    logic [15:0] dir_high_q;     // port_a_direction_high
    logic [15:0] func_high_q;    // port_a_function_high
    logic [15:0] func_l1_q;      // port_a_function_l1
    logic [15:0] func_l2_q;      // port_a_function_l2
    logic        debug_q;        // Registered debug mode
    logic [23:0] pin_level_q;    // Registered pad inputs

    // Bus side wires
    pfa_pkg::pfa_wr_t  wr;
    wire  logic [7:0]  rd_addr;
    logic [31:0]       rd_data;
    wire  logic        rd_ok;
    wire  logic        wr_ok;

    // Reserved masks, variant dependent
    wire  logic [15:0] func_high_rsvd;
    wire  logic [15:0] func_l1_rsvd;
    wire  logic [15:0] func_l2_rsvd;

    // Per-pin steering
    wire  logic [23:0] pin_dir;
    wire  logic [23:0] pin_dir_en;
    logic [23:0]       pin_sel;
    logic [23:0]       pin_val;
    logic [23:0]       pin_drv;
    pfa_pkg::pfa_pad_t pads_a [24];
    pfa_pkg::pfa_pad_t pads_e [5];

    // Write decode
    wire  logic wr_dir_low;
    wire  logic wr_dir_high;
    wire  logic wr_func_high;
    wire  logic wr_func_l1;
    wire  logic wr_func_l2;

    // Merge a write by byte lanes, then clear bits that read zero
    function automatic logic [15:0] pfa_merge(input logic [15:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb,
                                              input logic [15:0] rsvd);
        logic [15:0] v;
        v[7:0]  = strb[0] ? data[7:0] : old[7:0];
        v[15:8] = strb[1] ? data[15:8] : old[15:8];
        return v & ~rsvd;
    endfunction : pfa_merge

    // Bus slave
    pfa_axil_slave u_slave (
        .clk     (clk),
        .reset_n (reset_n),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .awaddr  (s_axi_awaddr[7:0]),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .bresp   (s_axi_bresp),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .araddr  (s_axi_araddr[7:0]),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .wr      (wr),
        .wr_ok   (wr_ok),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .rd_ok   (rd_ok)
    );

    assign func_high_rsvd = REDUCED_PIN ? `PFA_FUNC_HIGH_RSVD : 16'h0000;
    assign func_l1_rsvd   = REDUCED_PIN ? `PFA_FUNC_L1_RSVD : 16'h0000;
    assign func_l2_rsvd   = REDUCED_PIN ? `PFA_FUNC_L2_RSVD : 16'h0000;

    // Write address decode
    assign wr_dir_low   = wr.en && (wr.addr == `PFA_OFF_DIR_LOW);
    assign wr_dir_high  = wr.en && (wr.addr == `PFA_OFF_DIR_HIGH);
    assign wr_func_high = wr.en && (wr.addr == `PFA_OFF_FUNC_HIGH);
    assign wr_func_l1   = wr.en && (wr.addr == `PFA_OFF_FUNC_L1);
    assign wr_func_l2   = wr.en && (wr.addr == `PFA_OFF_FUNC_L2);
    assign wr_ok = (wr.addr == `PFA_OFF_DIR_LOW) || (wr.addr == `PFA_OFF_DIR_HIGH)
                || (wr.addr == `PFA_OFF_FUNC_HIGH) || (wr.addr == `PFA_OFF_FUNC_L1)
                || (wr.addr == `PFA_OFF_FUNC_L2) || (wr.addr == `PFA_OFF_PIN_LEVEL);

    // Direction registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dir_low_q  <= `PFA_RST_DIR;
            dir_high_q <= `PFA_RST_DIR;
        end else begin
            if (wr_dir_low) begin
                dir_low_q <= pfa_merge(dir_low_q, wr.data, wr.strb, 16'h0000);
            end
            if (wr_dir_high) begin
                dir_high_q <= pfa_merge(dir_high_q, wr.data, wr.strb, `PFA_DIR_HIGH_RSVD);
            end
        end
    end

    // Function-select registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            func_high_q <= `PFA_RST_FUNC;
            func_l1_q   <= `PFA_RST_FUNC;
            func_l2_q   <= `PFA_RST_FUNC;
        end else begin
            if (wr_func_high) begin
                func_high_q <= pfa_merge(func_high_q, wr.data, wr.strb, func_high_rsvd);
            end
            if (wr_func_l1) begin
                func_l1_q <= pfa_merge(func_l1_q, wr.data, wr.strb, func_l1_rsvd);
            end
            if (wr_func_l2) begin
                func_l2_q <= pfa_merge(func_l2_q, wr.data, wr.strb, func_l2_rsvd);
            end
        end
    end

    // Sampled pad levels and debug mode
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pin_level_q <= 24'h000000;
            debug_q     <= 1'b0;
        end else begin
            pin_level_q <= port_a_pin_in;
            debug_q     <= debug_mode_input;
        end
    end

    // Read decode
    assign rd_ok = (rd_addr == `PFA_OFF_DIR_LOW) || (rd_addr == `PFA_OFF_DIR_HIGH)
                || (rd_addr == `PFA_OFF_FUNC_HIGH) || (rd_addr == `PFA_OFF_FUNC_L1)
                || (rd_addr == `PFA_OFF_FUNC_L2) || (rd_addr == `PFA_OFF_PIN_LEVEL);
    always_comb begin
        if (rd_addr == `PFA_OFF_DIR_LOW) begin
            rd_data = {16'h0000, dir_low_q};
        end else if (rd_addr == `PFA_OFF_DIR_HIGH) begin
            rd_data = {16'h0000, dir_high_q};
        end else if (rd_addr == `PFA_OFF_FUNC_HIGH) begin
            rd_data = {16'h0000, func_high_q};
        end else if (rd_addr == `PFA_OFF_FUNC_L1) begin
            rd_data = {16'h0000, func_l1_q};
        end else if (rd_addr == `PFA_OFF_FUNC_L2) begin
            rd_data = {16'h0000, func_l2_q};
        end else if (rd_addr == `PFA_OFF_PIN_LEVEL) begin
            rd_data = {8'h00, pin_level_q};
        end else begin
            rd_data = 32'h00000000;
        end
    end

    assign pin_dir = {dir_high_q[7:0], dir_low_q};
    // low bits act for port and serial clocks
    // high bits act for port pins only, and only in the full variant (REDUCED_PIN clear)
    assign pin_dir_en = {{8{~REDUCED_PIN}}, 16'hFFFF};

    // Peripheral ownership per pin
    always_comb begin
        pin_sel = 24'h000000;
        pin_val = 24'h000000;
        pin_drv = 24'h000000;
        pin_sel[15] = func_l1_q[`PFA_BIT_PIN15_SEL];
        pin_val[15] = clock_generator_out;
        pin_drv[15] = 1'b1;
        pin_sel[14] = func_l1_q[`PFA_BIT_PIN14_SEL];
        pin_val[14] = read_strobe_out;
        pin_drv[14] = 1'b1;
        // upper write strobe on pin 13
        pin_sel[13] = func_l1_q[`PFA_BIT_PIN13_SEL];
        pin_val[13] = upper_write_strobe_out;
        pin_drv[13] = 1'b1;
        // serial clocks keep the direction bit
        pin_sel[`PFA_PIN_SERIAL_CLOCK_ZERO] = serial_clock_sel[0];
        pin_val[`PFA_PIN_SERIAL_CLOCK_ZERO] = serial_clock_zero_out;
        pin_drv[`PFA_PIN_SERIAL_CLOCK_ZERO] = dir_low_q[`PFA_PIN_SERIAL_CLOCK_ZERO];
        pin_sel[`PFA_PIN_SERIAL_CLOCK_ONE] = serial_clock_sel[1];
        pin_val[`PFA_PIN_SERIAL_CLOCK_ONE] = serial_clock_one_out;
        pin_drv[`PFA_PIN_SERIAL_CLOCK_ONE] = dir_low_q[`PFA_PIN_SERIAL_CLOCK_ONE];
    end

    for (genvar i = 0; i < 24; i++) begin : g_port_a
        pfa_pin_cell u_cell (
            .clk          (clk),
            .reset_n      (reset_n),
            .port_value   (port_a_data[i]),
            .dir_bit      (pin_dir[i]),
            .dir_enable   (pin_dir_en[i]),
            .periph_sel   (pin_sel[i]),
            .periph_value (pin_val[i]),
            .periph_drive (pin_drv[i]),
            .pad          (pads_a[i])
        );
        assign port_a_pad_out[i]  = pads_a[i].out;
        assign port_a_pad_oe_n[i] = pads_a[i].oe_n;
    end

    for (genvar j = 0; j < 5; j++) begin : g_port_e
        pfa_pin_cell u_cell (
            .clk          (clk),
            .reset_n      (reset_n),
            .port_value   (port_e_out[j]),
            .dir_bit      (~port_e_oe_n_in[j]),
            .dir_enable   (1'b1),
            .periph_sel   (debug_mode_input),
            .periph_value (jtag_tdo),
            .periph_drive (((~`PFA_JTAG_OE_N >> j) & 5'h01) != 5'h00),
            .pad          (pads_e[j])
        );
        assign port_e_pad_out[j]  = pads_e[j].out;
        assign port_e_pad_oe_n[j] = pads_e[j].oe_n;
    end
    assign debug_pins_fixed = debug_q;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_pin0_port;
        !pin_sel[0] ##0 dir_low_q[0];
    endsequence
    property p_dir_output;
        s_pin0_port |=> !port_a_pad_oe_n[0];
    endproperty
    a_dir_output: assert property (p_dir_output) else $error("pin 0 not driven");
    property p_dir_input;
        !dir_low_q[0] |=> port_a_pad_oe_n[0];
    endproperty
    a_dir_input: assert property (p_dir_input) else $error("pin 0 driven as input");
    property p_sck_dir;
        serial_clock_sel[0] |=> port_a_pad_oe_n[2] == !$past(dir_low_q[2]);
    endproperty
    a_sck_dir: assert property (p_sck_dir) else $error("serial clock dir wrong");
    property p_high_dir;
        dir_high_q[0] |=> port_a_pad_oe_n[16] == REDUCED_PIN;
    endproperty
    a_high_dir: assert property (p_high_dir) else $error("pin 16 drive wrong");
    property p_reset_dir;
        $rose(reset_n) |-> (dir_low_q == 16'h0000) && (dir_high_q == 16'h0000) ##1
            (port_a_pad_oe_n == 24'hFFFFFF);
    endproperty
    a_reset_dir: assert property (p_reset_dir) else $error("reset not input");
    property p_dir_high_rsvd;
        wr_dir_high |=> dir_high_q[15:8] == 8'h00;
    endproperty
    a_dir_high_rsvd: assert property (p_dir_high_rsvd) else $error("reserved set");
    property p_l1_write;
        wr_func_l1 && (wr.strb == 4'hF) |=> func_l1_q == ($past(wr.data[15:0]) & ~func_l1_rsvd);
    endproperty
    a_l1_write: assert property (p_l1_write) else $error("L1 write lost");
    property p_clk_out;
        func_l1_q[14] |=> port_a_pad_out[15] == $past(clock_generator_out)
            && !port_a_pad_oe_n[15];
    endproperty
    a_clk_out: assert property (p_clk_out) else $error("pin 15 clock wrong");
    property p_rd_strobe;
        func_l1_q[12] |=> port_a_pad_out[14] == $past(read_strobe_out);
    endproperty
    a_rd_strobe: assert property (p_rd_strobe) else $error("pin 14 strobe wrong");
    property p_wr_strobe;
        func_l1_q[10] && !dir_low_q[13] |=> !port_a_pad_oe_n[13]
            && port_a_pad_out[13] == $past(upper_write_strobe_out);
    endproperty
    a_wr_strobe: assert property (p_wr_strobe) else $error("pin 13 strobe wrong");
    property p_rsvd_l1;
        REDUCED_PIN |-> (func_l1_q & `PFA_FUNC_L1_RSVD) == 16'h0000;
    endproperty
    a_rsvd_l1: assert property (p_rsvd_l1) else $error("L1 reserved set");
    property p_debug_fix;
        debug_mode_input |=> port_e_pad_oe_n == `PFA_JTAG_OE_N
            && port_e_pad_out[`PFA_JTAG_OUT_PIN] == $past(jtag_tdo);
    endproperty
    a_debug_fix: assert property (p_debug_fix) else $error("port E not fixed");
endmodule : pfa_port_a_pfc
`default_nettype wire

// [pfa_regs.svh]
// Register offsets, field positions, masks and reset values of the port A pin function block
`ifndef PFA_REGS_SVH
`define PFA_REGS_SVH

// Byte offsets on the register bus
`define PFA_OFF_DIR_LOW    8'h00
`define PFA_OFF_DIR_HIGH   8'h04
`define PFA_OFF_FUNC_HIGH  8'h08
`define PFA_OFF_FUNC_L1    8'h0C
`define PFA_OFF_FUNC_L2    8'h10
`define PFA_OFF_PIN_LEVEL  8'h14

// Reset values
`define PFA_RST_DIR        16'h0000
`define PFA_RST_FUNC       16'h0000

// Bits that always read zero
`define PFA_DIR_HIGH_RSVD  16'hFF00
// Bits that read zero in the reduced-pin variant
`define PFA_FUNC_HIGH_RSVD 16'hAA08
`define PFA_FUNC_L1_RSVD   16'hAAA0
`define PFA_FUNC_L2_RSVD   16'h028A

// Function-select field positions in function register L1
`define PFA_BIT_PIN15_SEL  14
`define PFA_BIT_PIN14_SEL  12
`define PFA_BIT_PIN13_SEL  10

// Pins carrying the serial clocks
`define PFA_PIN_SERIAL_CLOCK_ZERO       2
`define PFA_PIN_SERIAL_CLOCK_ONE       5

// Debug-fixed port E pin that drives (test data out), others are inputs
`define PFA_JTAG_OUT_PIN   3
`define PFA_JTAG_OE_N      5'h17

// Bus answers
`define PFA_RESP_OKAY      2'h0
`define PFA_RESP_SLVERR    2'h2

`endif

// [pfa_pkg.sv]
// Types shared by the port A pin function block
package pfa_pkg;

    // One pad: output level and active-low drive enable
    typedef struct packed {
        logic out;
        logic oe_n;
    } pfa_pad_t;

    // One register write handed from the bus slave to the register file
    typedef struct packed {
        logic        en;
        logic [7:0]  addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } pfa_wr_t;

endpackage : pfa_pkg

// [pfa_pin_cell.sv]
// One pad cell: chooses port or peripheral drive and registers the pad outputs
`timescale 1ns/1ps
`default_nettype none
module pfa_pin_cell (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         port_value,   // Port data level
    input  wire logic         dir_bit,      // Direction bit, 1 is output
    input  wire logic         dir_enable,   // Direction bit has effect
    input  wire logic         periph_sel,   // Pin given to a peripheral
    input  wire logic         periph_value, // Peripheral output level
    input  wire logic         periph_drive, // Peripheral drives the pin
    output pfa_pkg::pfa_pad_t pad           // Registered pad outputs
);
    // Next pad value
    wire logic out_d;
    wire logic drive_d;

    // Peripheral owns the pin, else the port direction decides
    assign out_d   = periph_sel ? periph_value : port_value;
    assign drive_d = periph_sel ? periph_drive : (dir_bit & dir_enable);

    // Pad register, undriven at reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pad <= pfa_pkg::pfa_pad_t'(2'h1);
        end else begin
            pad.out  <= out_d;
            pad.oe_n <= ~drive_d;
        end
    end
endmodule : pfa_pin_cell
`default_nettype wire

// [pfa_axil_slave.sv]
// AXI4-Lite slave that turns bus transfers into register writes and reads
`include "pfa_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module pfa_axil_slave (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         awvalid,
    output logic              awready,
    input  wire logic [7:0]   awaddr,
    input  wire logic         wvalid,
    output logic              wready,
    input  wire logic [31:0]  wdata,
    input  wire logic [3:0]   wstrb,
    output logic              bvalid,
    input  wire logic         bready,
    output logic [1:0]        bresp,
    input  wire logic         arvalid,
    output logic              arready,
    input  wire logic [7:0]   araddr,
    output logic              rvalid,
    input  wire logic         rready,
    output logic [31:0]       rdata,
    output logic [1:0]        rresp,
    output pfa_pkg::pfa_wr_t  wr,       // Write to the register file
    input  wire logic         wr_ok,    // Write address is mapped
    output logic [7:0]        rd_addr,  // Read address to decode
    input  wire logic [31:0]  rd_data,  // Read data for rd_addr
    input  wire logic         rd_ok     // Read address is mapped
);
    // Held write halves
    logic        aw_have_q;
    logic [7:0]  aw_addr_q;
    logic        w_have_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    wire  logic  do_wr;

    // Each half is taken once, in either order
    assign awready = ~aw_have_q;
    assign wready  = ~w_have_q;
    assign do_wr   = aw_have_q & w_have_q & ~bvalid;
    assign wr      = '{en: do_wr, addr: aw_addr_q, data: w_data_q, strb: w_strb_q};
    assign arready = ~rvalid;
    assign rd_addr = araddr;

    // Write channels and response
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_have_q  <= 1'b0;
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
            bvalid    <= 1'b0;
            bresp     <= `PFA_RESP_OKAY;
        end else begin
            // Catch the address
            if (awvalid && awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= awaddr;
            end
            // Catch the data
            if (wvalid && wready) begin
                w_have_q <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            // Commit and answer
            if (do_wr) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid    <= 1'b1;
                bresp     <= wr_ok ? `PFA_RESP_OKAY : `PFA_RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Read answer, one edge after the address
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rvalid <= 1'b0;
            rdata  <= 32'h00000000;
            rresp  <= `PFA_RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= rd_ok ? rd_data : 32'h00000000;
            rresp  <= rd_ok ? `PFA_RESP_OKAY : `PFA_RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule : pfa_axil_slave
`default_nettype wire

// [pfa_periph_model.sv]
// Model of the peripherals and pads around port A
`timescale 1ns/1ps
`default_nettype none
module pfa_periph_model (
    input  wire logic   periph_invert,
    output logic [23:0] port_a_pin_in,
    output logic        clock_generator_out,
    output logic        read_strobe_out,
    output logic        upper_write_strobe_out,
    output logic        serial_clock_zero_out,
    output logic        serial_clock_one_out,
    output logic        jtag_tdo
);
    // Alternating levels so a swap between neighbouring sources shows; invert flips them all
    assign port_a_pin_in          = 24'h3C5A96 ^ {24{periph_invert}};
    assign clock_generator_out    = ~periph_invert;
    assign read_strobe_out        = periph_invert;
    assign upper_write_strobe_out = ~periph_invert;
    assign serial_clock_zero_out  = ~periph_invert;
    assign serial_clock_one_out   = periph_invert;
    assign jtag_tdo               = ~periph_invert;
endmodule : pfa_periph_model
`default_nettype wire

// [port_a_pin_function_control_tb_top.sv]
// Bench for the port A pin function block
`timescale 1ns/1ps
`default_nettype none
module port_a_pin_function_control_tb_top;
    logic clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, periph_invert, debug_mode_input;
    logic clock_generator_out, read_strobe_out, upper_write_strobe_out, serial_clock_zero_out;
    logic serial_clock_one_out, jtag_tdo, debug_pins_fixed;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, serial_clock_sel;
    logic [23:0] port_a_data, port_a_pin_in, port_a_pad_out, port_a_pad_oe_n;
    logic [4:0]  port_e_out, port_e_oe_n_in, port_e_pad_out, port_e_pad_oe_n;
    int bad_count, tests_run, cyc;
    // Design and far side
    pfa_port_a_pfc uut (.clk, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
        .s_axi_bready(1'b1), .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_rvalid, .s_axi_rready(1'b1), .s_axi_rdata, .s_axi_rresp, .port_a_data,
        .port_a_pin_in, .clock_generator_out, .read_strobe_out, .upper_write_strobe_out,
        .serial_clock_sel, .serial_clock_zero_out, .serial_clock_one_out, .port_a_pad_out,
        .port_a_pad_oe_n, .debug_mode_input, .port_e_out, .port_e_oe_n_in, .jtag_tdo,
        .port_e_pad_out, .port_e_pad_oe_n, .debug_pins_fixed);
    pfa_periph_model peer (.periph_invert, .port_a_pin_in, .clock_generator_out,
        .read_strobe_out, .upper_write_strobe_out, .serial_clock_zero_out,
        .serial_clock_one_out, .jtag_tdo);
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Bus write, response always accepted
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        s_axi_awvalid <= 1'b1; s_axi_awaddr <= {24'h0, a};
        s_axi_wvalid <= 1'b1; s_axi_wdata <= d; s_axi_wstrb <= 4'hF;
        while (!(aw && w)) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) begin aw = 1'b1; s_axi_awvalid <= 1'b0; end
            if (s_axi_wvalid && s_axi_wready) begin w = 1'b1; s_axi_wvalid <= 1'b0; end
        end
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask : wr
    // Bus read with expected data and answer
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        s_axi_arvalid <= 1'b1; s_axi_araddr <= {24'h0, a};
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rdata, e);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask : rd
    // Counts and verdict
    task automatic finish_test;
        $display("compares %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin bad_count++; finish_test(); end
    end
    initial begin
        reset_n = 1'b0; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_arvalid = 1'b0;
        s_axi_awaddr = 32'h0; s_axi_wdata = 32'h0; s_axi_wstrb = 4'h0; s_axi_araddr = 32'h0;
        periph_invert = 1'b0; debug_mode_input = 1'b0; serial_clock_sel = 2'h0;
        port_a_data = 24'h5A3C96; port_e_out = 5'h0A; port_e_oe_n_in = 5'h05;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        chk(32'(port_a_pad_oe_n), 32'h00FFFFFF);
        for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0, 2'h0);
        wr(8'h04, 32'hFFFFFFFF, 2'h0);
        rd(8'h04, 32'h00FF, 2'h0);
        wr(8'h00, 32'hFFFF, 2'h0);
        repeat (3) @(posedge clk);
        chk(32'(port_a_pad_oe_n), 32'h0);
        chk(32'(port_a_pad_out), 32'(port_a_data));
        wr(8'h04, 32'h0, 2'h0);
        wr(8'h08, 32'hFFFFFFFF, 2'h0);
        rd(8'h08, 32'hFFFF, 2'h0);
        wr(8'h10, 32'hFFFF, 2'h0);
        rd(8'h10, 32'hFFFF, 2'h0);
        wr(8'h0C, 32'h5400, 2'h0);
        rd(8'h0C, 32'h5400, 2'h0);
        // Peripherals own pins 15..13 even with direction bits set
        for (int k = 0; k < 2; k++) begin
            periph_invert <= 1'(k);
            repeat (3) @(posedge clk);
            chk(32'(port_a_pad_oe_n), 32'hFF0000);
            chk(32'(port_a_pad_out[15]), 32'(clock_generator_out));
            chk(32'(port_a_pad_out[14]), 32'(read_strobe_out));
            chk(32'(port_a_pad_out[13]), 32'(upper_write_strobe_out));
        end
        wr(8'h00, 32'h0, 2'h0);
        repeat (3) @(posedge clk);
        chk(32'(port_a_pad_oe_n), 32'hFF1FFF);
        // Serial clocks: direction drives, clock gives level
        serial_clock_sel <= 2'h3;
        wr(8'h00, 32'h0024, 2'h0);
        repeat (3) @(posedge clk);
        chk(32'(port_a_pad_oe_n), 32'hFF1FDB);
        chk(32'(port_a_pad_out[2]), 32'(serial_clock_zero_out));
        chk(32'(port_a_pad_out[5]), 32'(serial_clock_one_out));
        rd(8'h14, 32'(port_a_pin_in), 2'h0);
        rd(8'h18, 32'h0, 2'h2);
        wr(8'h18, 32'hFFFF, 2'h2);
        // Debug mode fixes port E pins
        debug_mode_input <= 1'b1;
        repeat (3) @(posedge clk);
        chk(32'(port_e_pad_oe_n), 32'h17);
        chk(32'(port_e_pad_out[3]), 32'(jtag_tdo));
        chk(32'(debug_pins_fixed), 32'h1);
        debug_mode_input <= 1'b0;
        repeat (3) @(posedge clk);
        chk(32'(port_e_pad_oe_n), 32'(port_e_oe_n_in));
        chk(32'(port_e_pad_out), 32'(port_e_out));
        finish_test();
    end
endmodule : port_a_pin_function_control_tb_top
`default_nettype wire
